//--- hdl/rf_timing_unit.sv
// Protocol timing unit: pulse trim, no-response timer, receive guard timer
`timescale 1ns/1ps
`default_nettype none
`include "rf_timing_consts.svh"

module rf_timing_unit (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic en,
	input wire logic regWrEn,
	input wire logic regRdEn,
	input wire logic [4:0] regAddr,
	input wire logic [7:0] regWrData,
	output logic [7:0] regRdData,
	input wire logic protoWrite,
	input wire rf_timing_pkg::proto_t protoSel,
	input wire logic modPulseReq,
	input wire logic txStart,
	input wire logic txEofDone,
	input wire logic txComplete,
	input wire logic fifoResetCmd,
	input wire logic rxSof,
	input wire logic flagClear,
	output logic modPulse,
	output logic decoderHold,
	output logic noRespIrq,
	output logic noRespFlag
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	rf_timing_pkg::state_t st_r; // Registered state
	rf_timing_pkg::state_t st_nxt; // Next state
	logic refTick; // 13.56 MHz enable pulse
	logic vicSel; // Vicinity protocol selected
	logic rxSeen; // Tag response outside guard
	logic [7:0] pulsePreset; // Protocol pulse length
	logic [7:0] pulseEff; // Pulse length in force

	// ----------------------------------------
	// Reference tick divider
	// ----------------------------------------
	rf_ref_tick refDiv (
		.clk(clk),
		.rst_n(rst_n),
		.refTick(refTick)
	);

	// Protocol dependent pulse length
	always_comb begin
		case (st_r.proto)
			rf_timing_pkg::PROTO_VIC_HIGH: pulsePreset = `PULSE_PRE_VIC;
			rf_timing_pkg::PROTO_VIC_LOW: pulsePreset = `PULSE_PRE_VIC;
			rf_timing_pkg::PROTO_A106: pulsePreset = `PULSE_PRE_A106;
			rf_timing_pkg::PROTO_A212: pulsePreset = `PULSE_PRE_A212;
			rf_timing_pkg::PROTO_A424: pulsePreset = `PULSE_PRE_A424;
			rf_timing_pkg::PROTO_A848: pulsePreset = `PULSE_PRE_A848;
			default: pulsePreset = `PULSE_PRE_A106;
		endcase
	end

	// Trim overrides the preset when nonzero
	assign pulseEff = (st_r.pulseLen == `RST_PULSE_TRIM) ? pulsePreset : st_r.pulseLen;
	// Vicinity modes are the only ones with slot timing
	assign vicSel = (st_r.proto == rf_timing_pkg::PROTO_VIC_HIGH) || (st_r.proto == rf_timing_pkg::PROTO_VIC_LOW);
	// Receiver input is ignored while decoders are held
	assign rxSeen = rxSof && !st_r.holdOn;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		st_nxt = st_r;
		st_nxt.irq = 1'b0;

		// Host register writes
		if (regWrEn) begin
			case (regAddr)
				`OFS_PULSE_TRIM: st_nxt.pulseLen = regWrData;
				`OFS_SILENCE_WAIT: st_nxt.silenceWait = regWrData;
				`OFS_GUARD_TIME: st_nxt.guardTime = regWrData;
				default: ;
			endcase
		end

		// Register read, unmapped reads zero
		if (regRdEn) begin
			case (regAddr)
				`OFS_PULSE_TRIM: st_nxt.rdData = st_r.pulseLen;
				`OFS_SILENCE_WAIT: st_nxt.rdData = st_r.silenceWait;
				`OFS_GUARD_TIME: st_nxt.rdData = st_r.guardTime;
				default: st_nxt.rdData = 8'h00;
			endcase
		end

		// Protocol selection reloads all three registers
		if (protoWrite) begin
			st_nxt.proto = protoSel;
			st_nxt.pulseLen = `RST_PULSE_TRIM;
			case (protoSel)
				rf_timing_pkg::PROTO_VIC_HIGH: begin
					st_nxt.silenceWait = `SIL_PRE_VIC_HIGH;
					st_nxt.guardTime = `GRD_PRE_VIC;
				end
				rf_timing_pkg::PROTO_VIC_LOW: begin
					st_nxt.silenceWait = `SIL_PRE_VIC_LOW;
					st_nxt.guardTime = `GRD_PRE_VIC;
				end
				rf_timing_pkg::PROTO_OTHER: begin
					st_nxt.silenceWait = `SIL_PRE_OTHER;
					st_nxt.guardTime = `GRD_PRE_OTHER;
				end
				default: begin
					st_nxt.silenceWait = `SIL_PRE_OTHER;
					st_nxt.guardTime = `GRD_PRE_PROX;
				end
			endcase
		end

		// Modulation pulse, counted in reference ticks
		if (!st_r.pulseOn && modPulseReq) begin
			st_nxt.pulseOn = 1'b1;
			st_nxt.pulseCnt = pulseEff;
		end else if (st_r.pulseOn && refTick) begin
			// One tick is one 73.7 ns unit
			if (st_r.pulseCnt <= 8'(`PULSE_UNIT_TICKS)) begin
				st_nxt.pulseOn = 1'b0;
			end else begin
				st_nxt.pulseCnt = st_r.pulseCnt - 8'h01;
			end
		end

		// Receive guard timer
		if (txEofDone) begin
			st_nxt.guardCnt = st_r.guardTime;
			st_nxt.guardPre = 7'h00;
			st_nxt.holdOn = (st_r.guardTime != 8'h00);
		end else if (st_r.holdOn && refTick) begin
			if (st_r.guardPre == `GUARD_PRE_LAST) begin
				// One guard unit elapsed
				st_nxt.guardPre = 7'h00;
				if (st_r.guardCnt == 8'h01) begin
					st_nxt.holdOn = 1'b0;
				end else begin
					st_nxt.guardCnt = st_r.guardCnt - 8'h01;
				end
			end else begin
				st_nxt.guardPre = st_r.guardPre + 7'h01;
			end
		end

		// Exchange bookkeeping for suppression
		if (txStart) begin
			st_nxt.txDoneSeen = 1'b0;
			st_nxt.suppress = 1'b0;
		end else begin
			if (txComplete) begin
				st_nxt.txDoneSeen = 1'b1;
			end
			if (fifoResetCmd && (st_r.txDoneSeen || txComplete)) begin
				st_nxt.suppress = 1'b1;
			end
		end

		// No-response timer
		case (st_r.silState)
			rf_timing_pkg::SIL_IDLE: begin
				// Start of slot at end of EOF, vicinity only
				if (txEofDone && vicSel && !st_r.suppress && st_r.silenceWait != 8'h00) begin
					st_nxt.silState = rf_timing_pkg::SIL_RUN;
					st_nxt.silCnt = st_r.silenceWait;
					st_nxt.silPre = 9'h000;
				end
			end
			rf_timing_pkg::SIL_RUN: begin
				if (rxSeen || !vicSel) begin
					// Tag answered or protocol changed
					st_nxt.silState = rf_timing_pkg::SIL_IDLE;
				end else if (refTick) begin
					if (st_r.silPre == `SILENCE_PRE_LAST) begin
						st_nxt.silPre = 9'h000;
						if (st_r.silCnt == 8'h01) begin
							// Empty slot detected
							st_nxt.silState = rf_timing_pkg::SIL_IDLE;
							st_nxt.irq = 1'b1;
						end else begin
							st_nxt.silCnt = st_r.silCnt - 8'h01;
						end
					end else begin
						st_nxt.silPre = st_r.silPre + 9'h001;
					end
				end
			end
			default: st_nxt.silState = rf_timing_pkg::SIL_IDLE;
		endcase

		// Suppression cancels a running timer
		if (st_nxt.suppress) begin
			st_nxt.silState = rf_timing_pkg::SIL_IDLE;
			st_nxt.irq = 1'b0;
		end

		// Status flag, setting beats clearing
		if (st_nxt.irq) begin
			st_nxt.flag = 1'b1;
		end else if (flagClear) begin
			st_nxt.flag = 1'b0;
		end

		// Enable low holds the defaults
		if (!en) begin
			st_nxt = '0;
			st_nxt.proto = rf_timing_pkg::PROTO_OTHER;
			st_nxt.pulseLen = `RST_PULSE_TRIM;
			st_nxt.silenceWait = `RST_SILENCE_WAIT;
			st_nxt.guardTime = `RST_GUARD_TIME;
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_r <= '0;
			st_r.proto <= rf_timing_pkg::PROTO_OTHER;
			st_r.pulseLen <= `RST_PULSE_TRIM;
			st_r.silenceWait <= `RST_SILENCE_WAIT;
			st_r.guardTime <= `RST_GUARD_TIME;
		end else begin
			st_r <= st_nxt;
		end
	end

	// Outputs straight from flops
	assign regRdData = st_r.rdData;
	assign modPulse = st_r.pulseOn;
	assign decoderHold = st_r.holdOn;
	assign noRespIrq = st_r.irq;
	assign noRespFlag = st_r.flag;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// Trim cleared on protocol selection
	a_trim_proto_clear: assert property (en && protoWrite |=> st_r.pulseLen == 8'h00)
		else $error("trim not cleared by protocol write");

	// Zero trim gives the protocol pulse
	a_pulse_preset: assert property (en && !protoWrite && !st_r.pulseOn && modPulseReq
		&& st_r.pulseLen == 8'h00 && st_r.proto == rf_timing_pkg::PROTO_A106
		|=> modPulse && st_r.pulseCnt == `PULSE_PRE_A106)
		else $error("preset pulse length not used");

	// Nonzero trim sets the pulse count
	a_pulse_trim: assert property (en && !st_r.pulseOn && modPulseReq && st_r.pulseLen != 8'h00
		|=> st_r.pulseCnt == $past(st_r.pulseLen))
		else $error("trim value not used for pulse");

	// Vicinity pulse preset value
	a_pulse_vic: assert property (en && !protoWrite && !st_r.pulseOn && modPulseReq
		&& st_r.pulseLen == 8'h00 && st_r.proto == rf_timing_pkg::PROTO_VIC_LOW
		|=> st_r.pulseCnt == `PULSE_PRE_VIC)
		else $error("vicinity pulse preset wrong");

	// Expiry raises both interrupt and flag
	a_irq_flag: assert property (noRespIrq |-> noRespFlag && $past(st_r.silState) == rf_timing_pkg::SIL_RUN)
		else $error("interrupt without flag or timer");

	// Silence counter steps once per unit
	a_silence_step: assert property (en && st_r.silState == rf_timing_pkg::SIL_RUN && refTick && !rxSeen
		&& vicSel && !st_nxt.suppress && st_r.silPre == `SILENCE_PRE_LAST && st_r.silCnt > 8'h01
		|=> st_r.silCnt == $past(st_r.silCnt) - 8'h01)
		else $error("silence unit step wrong");

	// Timer starts at end of EOF
	a_silence_start: assert property (en && txEofDone && vicSel && !st_r.suppress && !st_nxt.suppress
		&& st_r.silState == rf_timing_pkg::SIL_IDLE && st_r.silenceWait != 8'h00
		|=> st_r.silState == rf_timing_pkg::SIL_RUN && st_r.silCnt == $past(st_r.silenceWait))
		else $error("silence timer did not start");

	// Never fires outside vicinity
	a_silence_vic_only: assert property (noRespIrq |-> $past(vicSel))
		else $error("no-response outside vicinity protocol");

	// Suppressed exchange never interrupts
	a_suppress_quiet: assert property (st_r.suppress
		|-> !noRespIrq && st_r.silState == rf_timing_pkg::SIL_IDLE)
		else $error("suppressed timer still active");

	// Silence preset for high data rate
	a_silence_preset: assert property (en && protoWrite && protoSel == rf_timing_pkg::PROTO_VIC_HIGH
		|=> st_r.silenceWait == `SIL_PRE_VIC_HIGH)
		else $error("silence preset wrong");

	// Defaults with enable low
	a_silence_default: assert property (!en |=> st_r.silenceWait == `RST_SILENCE_WAIT)
		else $error("silence default wrong");

	// Decoders held right after EOF
	a_hold_after_eof: assert property (en && txEofDone && st_r.guardTime != 8'h00 |=> decoderHold [*2])
		else $error("decoders not held after EOF");

	// Guard counter loaded at EOF
	a_guard_load: assert property (en && txEofDone |=> st_r.guardCnt == $past(st_r.guardTime))
		else $error("guard count not loaded");

	// Guard preset for proximity A
	a_guard_preset: assert property (en && protoWrite && protoSel == rf_timing_pkg::PROTO_A106
		|=> st_r.guardTime == `GRD_PRE_PROX)
		else $error("guard preset wrong");

	// Guard default with enable low
	a_guard_default: assert property (!en |=> st_r.guardTime == `RST_GUARD_TIME)
		else $error("guard default wrong");

	// Reference ticks never adjacent
	a_tick_spacing: assert property (refTick |=> !refTick [*6])
		else $error("reference tick too frequent");

	// Main scenarios
	c_empty_slot: cover property (noRespIrq);
	c_trim_pulse: cover property ($fell(modPulse) && st_r.pulseLen != 8'h00);
	c_guard_done: cover property ($fell(decoderHold));
	c_suppressed: cover property ($rose(st_r.suppress));
endmodule // rf_timing_unit

`default_nettype wire

//--- hdl/rf_timing_consts.svh
// Offsets, reset values, presets and timing counts of the protocol timing unit
`ifndef RF_TIMING_CONSTS_SVH
`define RF_TIMING_CONSTS_SVH

// ----------------------------------------
// Register offsets and reset values
// ----------------------------------------
`define OFS_PULSE_TRIM 5'h06
`define OFS_SILENCE_WAIT 5'h07
`define OFS_GUARD_TIME 5'h08
`define RST_PULSE_TRIM 8'h00
`define RST_SILENCE_WAIT 8'h0E
`define RST_GUARD_TIME 8'h1E

// ----------------------------------------
// Clock rates and reference tick divider
// ----------------------------------------
`define CLK_KHZ 100000
`define REF_KHZ 13560
`define REF_STEP 17'(`REF_KHZ)
`define REF_MOD 17'(`CLK_KHZ)

// ----------------------------------------
// Time units (nominal figure, then ref ticks)
// ----------------------------------------
`define PULSE_UNIT_PS 73700
`define PULSE_UNIT_TICKS ((`PULSE_UNIT_PS * `REF_KHZ + 500000000) / 1000000000)
`define GUARD_UNIT_NS 9440
`define GUARD_UNIT_TICKS ((`GUARD_UNIT_NS * `REF_KHZ) / 1000000)
`define SILENCE_UNIT_NS 37760
`define SILENCE_UNIT_TICKS ((`SILENCE_UNIT_NS * `REF_KHZ) / 1000000)
`define GUARD_PRE_LAST 7'(`GUARD_UNIT_TICKS - 1)
`define SILENCE_PRE_LAST 9'(`SILENCE_UNIT_TICKS - 1)

// ----------------------------------------
// Protocol presets, rounded to whole units
// ----------------------------------------
`define NS_TO_TICKS(ns) (((ns) * `REF_KHZ + 500000) / 1000000)
`define PULSE_PRE_VIC 8'(`NS_TO_TICKS(9440))
`define PULSE_PRE_A106 8'(`NS_TO_TICKS(2360))
`define PULSE_PRE_A212 8'(`NS_TO_TICKS(1400))
`define PULSE_PRE_A424 8'(`NS_TO_TICKS(737))
`define PULSE_PRE_A848 8'(`NS_TO_TICKS(442))
`define US_TO_SIL(us) 8'(((us) * 1000 + `SILENCE_UNIT_NS / 2) / `SILENCE_UNIT_NS)
`define SIL_PRE_VIC_HIGH `US_TO_SIL(755)
`define SIL_PRE_VIC_LOW `US_TO_SIL(1812)
`define SIL_PRE_OTHER `US_TO_SIL(529)
`define US_TO_GRD(us) 8'(((us) * 1000 + `GUARD_UNIT_NS / 2) / `GUARD_UNIT_NS)
`define GRD_PRE_PROX `US_TO_GRD(66)
`define GRD_PRE_VIC `US_TO_GRD(293)
`define GRD_PRE_OTHER 8'(1)

`endif

//--- hdl/rf_timing_pkg.sv
// Types of the protocol timing unit
`default_nettype none

package rf_timing_pkg;
	// Selected card protocol
	typedef enum logic [2:0] {
		PROTO_VIC_HIGH,
		PROTO_VIC_LOW,
		PROTO_A106,
		PROTO_A212,
		PROTO_A424,
		PROTO_A848,
		PROTO_PROX_B,
		PROTO_OTHER
	} proto_t;

	// No-response timer states
	typedef enum logic {
		SIL_IDLE,
		SIL_RUN
	} sil_state_t;

	// Whole state of the timing unit
	typedef struct packed {
		logic [7:0] pulseLen;
		logic [7:0] silenceWait;
		logic [7:0] guardTime;
		proto_t proto;
		logic [7:0] pulseCnt;
		logic pulseOn;
		logic [6:0] guardPre;
		logic [7:0] guardCnt;
		logic holdOn;
		sil_state_t silState;
		logic [8:0] silPre;
		logic [7:0] silCnt;
		logic suppress;
		logic txDoneSeen;
		logic irq;
		logic flag;
		logic [7:0] rdData;
	} state_t;
endpackage

`default_nettype wire

//--- hdl/rf_ref_tick.sv
// Fractional divider giving a 13.56 MHz reference tick
`timescale 1ns/1ps
`default_nettype none
`include "rf_timing_consts.svh"

module rf_ref_tick (
	input wire logic clk,
	input wire logic rst_n,
	output logic refTick
);
	// Phase accumulator and tick flop
	typedef struct packed {
		logic [16:0] acc;
		logic tick;
	} tick_state_t;

	tick_state_t st_r;
	tick_state_t st_nxt;

	// Next phase and overflow
	always_comb begin
		st_nxt = st_r;
		st_nxt.tick = 1'b0;
		if (st_r.acc + `REF_STEP >= `REF_MOD) begin
			st_nxt.acc = 17'(st_r.acc + `REF_STEP - `REF_MOD);
			st_nxt.tick = 1'b1;
		end else begin
			st_nxt.acc = 17'(st_r.acc + `REF_STEP);
		end
	end

	// Registered state
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign refTick = st_r.tick;
endmodule // rf_ref_tick

`default_nettype wire

//--- tb/rf_tag_model.sv
// Behavioural contactless tag that answers after the reader's end of frame
`timescale 1ns/1ps
`default_nettype none

module rf_tag_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic txEofDone,
	input wire logic answer,
	input wire logic [15:0] replyDelay,
	output logic rxSof
);
	logic [15:0] replyCnt_r; // Cycles left until the reply starts
	logic busy_r; // A reply is pending

	// ----------------------------------------
	// Reply timing
	// ----------------------------------------
	// A tag only speaks after a request frame, then after its own delay
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			busy_r <= 1'b0;
			replyCnt_r <= 16'h0000;
			rxSof <= 1'b0;
		end else if (txEofDone && answer) begin
			busy_r <= 1'b1;
			replyCnt_r <= replyDelay;
			rxSof <= 1'b0;
		end else if (busy_r && replyCnt_r == 16'h0000) begin
			busy_r <= 1'b0;
			rxSof <= 1'b1;
		end else begin
			replyCnt_r <= busy_r ? replyCnt_r - 16'h0001 : replyCnt_r;
			rxSof <= 1'b0;
		end
	end
endmodule // rf_tag_model
`default_nettype wire

//--- tb/rf_reader_protocol_timing_bench.sv
// Self-checking bench of the protocol timing unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; $display("ERROR %0t: got %0h exp %0h", $time, g, e); end end

module rf_reader_protocol_timing_bench;
	logic clk, rst_n, en, regWrEn, regRdEn, rxSof, answer; // Bench-driven controls, rxSof from the tag model
	logic [4:0] regAddr; // Register offset
	logic [7:0] regWrData, regRdData; // Register data
	logic [15:0] replyDelay; // Tag reply delay in cycles
	logic [6:0] ev; // Event pulses: proto, mod, txStart, eof, txDone, fifoRst, flagClr
	rf_timing_pkg::proto_t protoSel; // Protocol value
	logic modPulse, decoderHold, noRespIrq, noRespFlag; // Design outputs
	wire logic [3:0] outs = {noRespFlag, noRespIrq, decoderHold, modPulse};
	int err_count, cmp_count, d, l, n; // Counters and measurements
	int pn[6] = '{128, 128, 32, 19, 10, 6}; // Preset pulse ticks per protocol
	int tv[3] = '{1, 3, 255}; // Trim values tried

	rf_timing_unit DUT (.clk(clk), .rst_n(rst_n), .en(en), .regWrEn(regWrEn), .regRdEn(regRdEn),
		.regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData), .protoWrite(ev[0]),
		.protoSel(protoSel), .modPulseReq(ev[1]), .txStart(ev[2]), .txEofDone(ev[3]),
		.txComplete(ev[4]), .fifoResetCmd(ev[5]), .rxSof(rxSof), .flagClear(ev[6]),
		.modPulse(modPulse), .decoderHold(decoderHold), .noRespIrq(noRespIrq), .noRespFlag(noRespFlag));

	rf_tag_model tag (.clk(clk), .rst_n(rst_n), .txEofDone(ev[3]), .answer(answer),
		.replyDelay(replyDelay), .rxSof(rxSof));

	// ----------------------------------------
	// Clock
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// Verdict and end of run
	task automatic print_verdict;
		$display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Register write, one strobe cycle
	task automatic wr(input logic [4:0] a, input logic [7:0] v);
		@(negedge clk);
		regAddr = a;
		regWrData = v;
		regWrEn = 1'b1;
		@(negedge clk);
		regWrEn = 1'b0;
	endtask

	// Register read and compare, data valid the cycle after the strobe
	task automatic rdc(input logic [4:0] a, input logic [7:0] e);
		@(negedge clk);
		regAddr = a;
		regRdEn = 1'b1;
		@(negedge clk);
		regRdEn = 1'b0;
		`CHK(regRdData, e)
	endtask

	// One-cycle event pulse
	task automatic pulse(input int b);
		@(negedge clk);
		ev[b] = 1'b1;
		@(negedge clk);
		ev = 7'h00;
	endtask

	// Protocol selection write
	task automatic proto(input int p);
		protoSel = rf_timing_pkg::proto_t'(p);
		pulse(0);
	endtask

	// Delay to rise and length high of one output, bounded
	task automatic span(input int s, output int dl, output int ln);
		dl = 0;
		ln = 0;
		while (outs[s] !== 1'b1 && dl < 20000) begin
			@(negedge clk);
			dl++;
		end
		while (outs[s] === 1'b1 && ln < 20000) begin
			@(negedge clk);
			ln++;
		end
		if (dl >= 20000 || ln >= 20000) begin
			err_count++;
			$display("ERROR %0t: wait limit reached", $time);
			print_verdict;
		end
	endtask

	// Count interrupt pulses over a stretch of cycles
	task automatic quiet(output int hits);
		hits = 0;
		repeat (4200) begin
			@(negedge clk);
			hits += (noRespIrq !== 1'b0);
		end
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		rst_n = 1'b0;
		en = 1'b1;
		regWrEn = 1'b0;
		regRdEn = 1'b0;
		regAddr = 5'h00;
		regWrData = 8'h00;
		ev = 7'h00;
		answer = 1'b0;
		replyDelay = 16'h07D0;
		protoSel = rf_timing_pkg::PROTO_OTHER;
		err_count = 0;
		cmp_count = 0;
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		// Reset values, unmapped place, readback
		rdc(5'h06, 8'h00);
		rdc(5'h07, 8'h0E);
		rdc(5'h08, 8'h1E);
		wr(5'h10, 8'hAA);
		rdc(5'h10, 8'h00);
		wr(5'h07, 8'h20);
		rdc(5'h07, 8'h20);
		$display("test reset done");
		// Presets for every protocol, trim cleared each time
		for (int p = 0; p < 8; p++) begin
			wr(5'h06, 8'h55);
			proto(p);
			rdc(5'h06, 8'h00);
			rdc(5'h07, (p == 0) ? 8'h14 : (p == 1) ? 8'h30 : 8'h0E);
			rdc(5'h08, (p < 2) ? 8'h1F : (p == 7) ? 8'h01 : 8'h07);
		end
		$display("test presets done");
		// Preset pulse lengths with zero trim
		for (int p = 0; p < 6; p++) begin
			proto(p);
			pulse(1);
			span(0, d, l);
			`CHK(l >= (pn[p] - 1) * 7 && l <= pn[p] * 8 + 2, 1'b1)
		end
		// Programmed trim overrides the preset
		proto(2);
		for (int i = 0; i < 3; i++) begin
			wr(5'h06, 8'(tv[i]));
			pulse(1);
			span(0, d, l);
			`CHK(l >= (tv[i] - 1) * 7 && l <= tv[i] * 8 + 2, 1'b1)
		end
		$display("test pulse done");
		// Guard hold of two units after end of frame
		wr(5'h08, 8'h02);
		pulse(3);
		span(1, d, l);
		`CHK(d == 0 && l >= 1880 && l <= 1896, 1'b1)
		$display("test guard done");
		// Silent slot of two units in vicinity mode
		proto(0);
		wr(5'h07, 8'h02);
		wr(5'h08, 8'h01);
		pulse(2);
		pulse(3);
		span(2, d, l);
		`CHK(d >= 7544 && d <= 7560 && l == 1, 1'b1)
		`CHK(noRespFlag, 1'b1)
		pulse(6);
		`CHK(noRespFlag, 1'b0)
		// Tag answers after the guard, so no interrupt
		wr(5'h07, 8'h01);
		answer = 1'b1;
		pulse(3);
		quiet(n);
		`CHK(n, 0)
		answer = 1'b0;
		// Other protocol: no detection at all
		proto(2);
		wr(5'h07, 8'h01);
		pulse(2);
		pulse(3);
		quiet(n);
		`CHK(n + noRespFlag, 0)
		// FIFO reset after transmit complete suppresses, next transmit restores
		proto(0);
		wr(5'h07, 8'h01);
		pulse(2);
		pulse(3);
		pulse(4);
		pulse(5);
		quiet(n);
		`CHK(n, 0)
		pulse(2);
		pulse(3);
		span(2, d, l);
		`CHK(d >= 3768 && d <= 3784, 1'b1)
		$display("test silence done");
		// Enable low restores defaults
		wr(5'h06, 8'h05);
		wr(5'h07, 8'h33);
		wr(5'h08, 8'h44);
		en = 1'b0;
		repeat (2) @(negedge clk);
		en = 1'b1;
		rdc(5'h06, 8'h00);
		rdc(5'h07, 8'h0E);
		rdc(5'h08, 8'h1E);
		$display("test enable done");
		print_verdict;
	end
endmodule // rf_reader_protocol_timing_bench
`default_nettype wire
